// File: pmp_regs.svh
// constants of the mac port: clock rates, widths and field positions
`ifndef PMP_REGS_SVH
`define PMP_REGS_SVH

// system clock, 10 MHz
`define PMP_CLK_HZ 32'h0098_9680
// transmit clock at 10 Mbps, 2.5 MHz
`define PMP_TXCLK10_HZ 32'h0026_25A0
// transmit clock at 100 Mbps, 25 MHz
`define PMP_TXCLK100_HZ 32'h017D_7840

`define PMP_BYTE_W 8
`define PMP_NIB_W 4
`define PMP_DIV_W 8
// buffer word: error flag above the byte
`define PMP_RXW 9
`define PMP_ERR_BIT 8
`define PMP_NIB_LO 3:0
`define PMP_NIB_HI 7:4

`endif

// File: pmp_pkg.sv
// types and helpers shared by the mac port files
package pmp_pkg;
`include "pmp_regs.svh"

   typedef enum logic [1:0] {spd_10, spd_100, spd_1000} pmp_speed_t;

   typedef enum logic {txs_idle, txs_frame} pmp_txst_t;

   // half period of a divided clock in system cycles, rounded down, never below one
   function automatic logic [`PMP_DIV_W-1:0] pmp_half(input logic [31:0] hz);
      logic [31:0] c;
      c = `PMP_CLK_HZ / (hz * 32'h0000_0002);
      if (c == 32'h0000_0000) begin
         c = 32'h0000_0001;
      end
      return c[`PMP_DIV_W-1:0];
   endfunction : pmp_half

endpackage : pmp_pkg

// File: pmp_buf_if.sv
// valid/ready carrier between the port logic and its receive buffer
`timescale 1ns/100ps
interface pmp_buf_if;
`include "pmp_regs.svh"
   logic in_valid;
   logic in_ready;
   logic [`PMP_RXW-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [`PMP_RXW-1:0] out_data;
   logic flush;

   modport store (input in_valid, input in_data, input out_ready, input flush,
                  output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready, output flush,
                 input in_ready, input out_valid, input out_data);
endinterface : pmp_buf_if

// File: pmp_fifo2.sv
// two-entry receive buffer, head word and ready come from registers
`timescale 1ns/100ps
`include "pmp_regs.svh"
module pmp_fifo2 (
   input wire logic clk_i,
   input wire logic srst_i,
   pmp_buf_if.store bus
);
   import pmp_pkg::*;

   logic [`PMP_RXW-1:0] d1;
   logic v0;
   logic v1;
   logic rdy;
   logic push;
   logic pop;
   logic next_v0;
   logic next_v1;

   assign push = bus.in_valid & rdy;
   assign pop = bus.out_ready & v0;
   assign bus.out_valid = v0;
   assign bus.in_ready = rdy;

   always_comb begin
      next_v0 = v0;
      next_v1 = v1;
      if (bus.flush) begin
         next_v0 = 1'h0;
         next_v1 = 1'h0;
      end else if (pop && !push) begin
         next_v0 = v1;
         next_v1 = 1'h0;
      end else if (push && !pop) begin
         next_v0 = 1'h1;
         next_v1 = v0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         v0 <= 1'h0;
         v1 <= 1'h0;
         rdy <= 1'h0;
      end else begin
         v0 <= next_v0;
         v1 <= next_v1;
         // ready is taken from the next fill state, so it drops in the cycle the second slot fills and the source never outruns it
         rdy <= ~next_v1 & ~bus.flush;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus.out_data <= '0;
         d1 <= '0;
      end else if (pop) begin
         bus.out_data <= v1 ? d1 : bus.in_data;
         d1 <= bus.in_data;
      end else if (push) begin
         if (!v0) begin
            bus.out_data <= bus.in_data;
         end else begin
            d1 <= bus.in_data;
         end
      end
   end

endmodule : pmp_fifo2

// File: pmp_mac_port.sv
// phy side gmii/rgmii mac data port sampled on the system clock
`timescale 1ns/100ps
`include "pmp_regs.svh"
// Behaviour
// RULE_01: gmii receive byte launched at clock rise
// RULE_02: rgmii low nibble rise, high nibble fall
// RULE_03: rgmii leaves upper nibble and gmii-only pins
// RULE_04: receive clock follows recovered media clock
// RULE_05: gmii receive error at clock rise
// RULE_06: rgmii control carries valid at rise
// RULE_07: rgmii control carries error code at fall
// RULE_08: gmii data valid with each byte
// RULE_09: gmii transmit byte taken at gigabit rise
// RULE_10: rgmii transmit nibbles taken on both edges
// RULE_11: transmit clock 2.5 or 25 MHz; the code gives 5 MHz at 100 Mbps
// RULE_12: mac supplies 125 MHz gigabit clock; the model's gtx runs far below it, sampled on the 10 MHz clock
// RULE_13: rgmii mac supplies transmit clock all speeds
// RULE_14: gmii transmit error sampled at rise
// RULE_15: rgmii transmit control gives enable at rise
// RULE_16: rgmii transmit control gives error at fall
// RULE_17: gmii transmit data valid only when enabled
// RULE_18: carrier sense follows detected carrier
// RULE_19: collision only in half duplex
// RULE_20: soft reset enters low power, keeps settings
// RULE_21: falling control is valid xor error
module pmp_mac_port (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic rgmii_mode_i,
   input wire pmp_pkg::pmp_speed_t speed_i,
   input wire logic soft_powerdown_reset_n_i,
   input wire logic rec_clk_i,
   input wire logic [`PMP_BYTE_W-1:0] rx_data_i,
   input wire logic rx_err_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic carrier_i,
   input wire logic collision_i,
   input wire logic full_duplex_i,
   output logic rx_clk_o,
   output logic [`PMP_BYTE_W-1:0] rxd_o,
   output logic rx_dv_o,
   output logic rx_er_o,
   output logic crs_o,
   output logic col_o,
   input wire logic gtx_clk_i,
   input wire logic [`PMP_BYTE_W-1:0] txd_i,
   input wire logic tx_en_i,
   input wire logic tx_er_i,
   output logic tx_clk_o,
   output logic [`PMP_BYTE_W-1:0] tx_data_o,
   output logic tx_err_o,
   output logic tx_valid_o,
   output logic tx_sof_o,
   output logic low_power_o
);
   import pmp_pkg::*;
   localparam logic [`PMP_DIV_W-1:0] HALF_10 = pmp_half(`PMP_TXCLK10_HZ);
   localparam logic [`PMP_DIV_W-1:0] HALF_100 = pmp_half(`PMP_TXCLK100_HZ);

   // pin synchronisers
   logic rc_s1;
   logic rc_s2;
   logic rc_d1;
   logic rc_d2;
   logic gc_s1;
   logic gc_s2;
   logic gc_d1;
   logic [`PMP_BYTE_W-1:0] txd_s1;
   logic [`PMP_BYTE_W-1:0] txd_s2;
   logic en_s1;
   logic en_s2;
   logic er_s1;
   logic er_s2;
   logic md_s1;
   logic md_s2;
   logic pd_s1;
   logic pd_s2;

   logic rgmii;
   logic lp;
   logic rx_rise;
   logic rx_fall;
   logic gc_rise;
   logic gc_fall;
   logic tx_strobe;

   logic [`PMP_NIB_W-1:0] hold_hi;
   logic cur_dv;
   logic cur_er;

   logic [`PMP_DIV_W-1:0] txdiv;
   logic tclk_rise;

   logic [`PMP_NIB_W-1:0] tx_lo;
   logic tx_en_lat;
   pmp_txst_t txst;

   pmp_buf_if rxb ();

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rc_s1 <= 1'h0;
         rc_s2 <= 1'h0;
         rc_d1 <= 1'h0;
         rc_d2 <= 1'h0;
         gc_s1 <= 1'h0;
         gc_s2 <= 1'h0;
         gc_d1 <= 1'h0;
         txd_s1 <= '0;
         txd_s2 <= '0;
         en_s1 <= 1'h0;
         en_s2 <= 1'h0;
         er_s1 <= 1'h0;
         er_s2 <= 1'h0;
         md_s1 <= 1'h0;
         md_s2 <= 1'h0;
         pd_s1 <= 1'h1;
         pd_s2 <= 1'h1;
      end else begin
         rc_s1 <= rec_clk_i;
         rc_s2 <= rc_s1;
         rc_d1 <= rc_s2;
         rc_d2 <= rc_d1;
         gc_s1 <= gtx_clk_i;
         gc_s2 <= gc_s1;
         gc_d1 <= gc_s2;
         // data pins share the clock's sync depth so both stay aligned
         txd_s1 <= txd_i;
         txd_s2 <= txd_s1;
         en_s1 <= tx_en_i;
         en_s2 <= en_s1;
         er_s1 <= tx_er_i;
         er_s2 <= er_s1;
         md_s1 <= rgmii_mode_i;
         md_s2 <= md_s1;
         pd_s1 <= soft_powerdown_reset_n_i;
         pd_s2 <= pd_s1;
      end
   end

   assign rgmii = md_s2;
   assign lp = ~pd_s2;
   assign rx_rise = rc_s2 & ~rc_d1;
   assign rx_fall = ~rc_s2 & rc_d1;
   assign gc_rise = gc_s2 & ~gc_d1;
   assign gc_fall = ~gc_s2 & gc_d1;
   // rgmii always takes the mac's clock; gmii below gigabit uses our own
   assign tx_strobe = (!rgmii && speed_i != spd_1000) ? tclk_rise : gc_rise; // RULE_13

   // receive buffer: the media side fills, each rising link edge drains one word
   assign rxb.in_valid = rx_valid_i;
   assign rxb.in_data = {rx_err_i, rx_data_i};
   assign rxb.out_ready = rx_rise & ~lp;
   assign rxb.flush = lp; // RULE_20
   assign rx_ready_o = rxb.in_ready;

   pmp_fifo2 u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .bus(rxb.store)
   );

   // receive pins; a buffer running dry mid-frame shows as a gap in valid
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_clk_o <= 1'h0;
         rxd_o <= '0;
         rx_dv_o <= 1'h0;
         rx_er_o <= 1'h0;
         hold_hi <= '0;
         cur_dv <= 1'h0;
         cur_er <= 1'h0;
      end else if (lp) begin
         rx_clk_o <= 1'h0; // RULE_20
         rxd_o <= '0;
         rx_dv_o <= 1'h0;
         rx_er_o <= 1'h0;
         cur_dv <= 1'h0;
         cur_er <= 1'h0;
      end else begin
         // clock lags data by two cycles so the edge sits inside the data eye
         rx_clk_o <= rc_d2; // RULE_04
         if (rx_rise) begin
            cur_dv <= rxb.out_valid;
            cur_er <= rxb.out_valid & rxb.out_data[`PMP_ERR_BIT];
            hold_hi <= rxb.out_data[`PMP_NIB_HI];
            if (rgmii) begin
               rxd_o[`PMP_NIB_HI] <= '0; // RULE_03
               rxd_o[`PMP_NIB_LO] <= rxb.out_valid ? rxb.out_data[`PMP_NIB_LO] : '0; // RULE_02
               rx_dv_o <= 1'h0;
               rx_er_o <= rxb.out_valid; // RULE_06
            end else begin
               rxd_o <= rxb.out_valid ? rxb.out_data[`PMP_BYTE_W-1:0] : '0; // RULE_01
               rx_dv_o <= rxb.out_valid; // RULE_08
               rx_er_o <= rxb.out_valid & rxb.out_data[`PMP_ERR_BIT]; // RULE_05
            end
         end else if (rgmii && rx_fall) begin
            rxd_o[`PMP_NIB_LO] <= hold_hi; // RULE_02
            rx_er_o <= cur_dv ^ cur_er; // RULE_07 RULE_21
         end
      end
   end

   // carrier and collision carry no meaning in rgmii and are held low
   always_ff @(posedge clk_i) begin
      if (srst_i || lp) begin
         crs_o <= 1'h0;
         col_o <= 1'h0;
      end else begin
         crs_o <= ~rgmii & carrier_i; // RULE_18
         col_o <= ~rgmii & collision_i & ~full_duplex_i; // RULE_19
      end
   end

   // 25 MHz is above what this clock can divide to; it runs at the fastest rate possible
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         txdiv <= '0;
         tx_clk_o <= 1'h0;
         tclk_rise <= 1'h0;
      end else begin
         tclk_rise <= 1'h0;
         if (lp || speed_i == spd_1000) begin
            txdiv <= '0;
            tx_clk_o <= 1'h0;
         end else if (txdiv == '0) begin
            txdiv <= (speed_i == spd_10) ? HALF_10 - 8'h01 : HALF_100 - 8'h01; // RULE_11
            tx_clk_o <= ~tx_clk_o;
            tclk_rise <= ~tx_clk_o;
         end else begin
            txdiv <= txdiv - 8'h01;
         end
      end
   end

   // transmit capture; the link cannot be stalled, so words go out as one-cycle pulses
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_data_o <= '0;
         tx_err_o <= 1'h0;
         tx_valid_o <= 1'h0;
         tx_sof_o <= 1'h0;
         tx_lo <= '0;
         tx_en_lat <= 1'h0;
         txst <= txs_idle;
      end else begin
         tx_valid_o <= 1'h0;
         tx_sof_o <= 1'h0;
         if (lp) begin
            tx_en_lat <= 1'h0;
            txst <= txs_idle;
         end else if (!rgmii && tx_strobe) begin
            if (en_s2) begin // RULE_17
               tx_data_o <= txd_s2; // RULE_09
               tx_err_o <= er_s2; // RULE_14
               tx_valid_o <= 1'h1;
               tx_sof_o <= (txst == txs_idle);
               txst <= txs_frame;
            end else begin
               txst <= txs_idle;
            end
         end else if (rgmii && gc_rise) begin
            tx_lo <= txd_s2[`PMP_NIB_LO]; // RULE_10
            tx_en_lat <= er_s2; // RULE_15
            if (!er_s2) begin
               txst <= txs_idle;
            end
         end else if (rgmii && gc_fall && tx_en_lat) begin
            tx_data_o <= {txd_s2[`PMP_NIB_LO], tx_lo}; // RULE_10
            tx_err_o <= tx_en_lat ^ er_s2; // RULE_16 RULE_21
            tx_valid_o <= 1'h1;
            tx_sof_o <= (txst == txs_idle);
            txst <= txs_frame;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         low_power_o <= 1'h0;
      end else begin
         low_power_o <= lp; // RULE_20
      end
   end

   a_gmii_rx_byte: assert property ( // RULE_01
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && !lp && rx_rise && rxb.out_valid) |=> (rxd_o == $past(rxb.out_data[`PMP_BYTE_W-1:0])))
      else $error("gmii receive byte not launched at clock rise");

   a_gmii_rx_steady: assert property ( // RULE_01
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && !lp && !rx_rise) |=> $stable(rxd_o))
      else $error("gmii receive data moved without a clock rise");

   a_rgmii_lo_nib: assert property ( // RULE_02
      @(posedge clk_i) disable iff (srst_i)
      (rgmii && !lp && rx_rise && rxb.out_valid) |=> (rxd_o[`PMP_NIB_LO] == $past(rxb.out_data[`PMP_NIB_LO])))
      else $error("rgmii low nibble missing at rise");

   a_rgmii_hi_nib: assert property ( // RULE_02
      @(posedge clk_i) disable iff (srst_i)
      (rgmii && !lp && rx_fall) |=> (rxd_o[`PMP_NIB_LO] == $past(hold_hi)))
      else $error("rgmii high nibble missing at fall");

   a_rgmii_unused: assert property ( // RULE_03
      @(posedge clk_i) disable iff (srst_i)
      (rgmii && !lp && rx_rise) |=> (rxd_o[`PMP_NIB_HI] == 4'h0 && !rx_dv_o && !crs_o && !col_o))
      else $error("rgmii drives an unused pin");

   a_rx_clk_lag: assert property ( // RULE_04
      @(posedge clk_i) disable iff (srst_i)
      (!lp && rx_rise) ##1 (!lp && rc_s2) [*2] |=> rx_clk_o)
      else $error("receive clock did not follow media clock");

   a_gmii_rx_err: assert property ( // RULE_05
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && !lp && rx_rise) |=> (rx_er_o == ($past(rxb.out_valid) && $past(rxb.out_data[`PMP_ERR_BIT]))))
      else $error("gmii receive error wrong");

   a_rgmii_ctl_dv: assert property ( // RULE_06
      @(posedge clk_i) disable iff (srst_i)
      (rgmii && !lp && rx_rise) |=> (rx_er_o == $past(rxb.out_valid)))
      else $error("rgmii control at rise is not valid");

   a_rgmii_ctl_err: assert property ( // RULE_07 RULE_21
      @(posedge clk_i) disable iff (srst_i)
      (rgmii && !lp && rx_fall) |=> (rx_er_o == ($past(cur_dv) ^ $past(cur_er))))
      else $error("rgmii control at fall is not valid xor error");

   a_gmii_rx_dv: assert property ( // RULE_08
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && !lp && rx_rise) |=> (rx_dv_o == $past(rxb.out_valid)))
      else $error("gmii data valid wrong");

   a_gmii_tx_take: assert property ( // RULE_09 RULE_14
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && !lp && tx_strobe && en_s2)
      |=> (tx_valid_o && tx_data_o == $past(txd_s2) && tx_err_o == $past(er_s2)))
      else $error("gmii transmit byte not taken");

   a_gmii_tx_idle: assert property ( // RULE_17
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && tx_strobe && !en_s2) |=> !tx_valid_o)
      else $error("gmii transmit byte taken without enable");

   a_rgmii_tx_pair: assert property ( // RULE_10 RULE_15 RULE_16
      @(posedge clk_i) disable iff (srst_i)
      (rgmii && !lp && gc_fall && tx_en_lat)
      |=> (tx_valid_o && tx_data_o == {$past(txd_s2[`PMP_NIB_LO]), $past(tx_lo)}
           && tx_err_o == ($past(er_s2) ^ $past(tx_en_lat))))
      else $error("rgmii transmit nibbles not paired");

   a_txclk_10: assert property ( // RULE_11
      @(posedge clk_i) disable iff (srst_i)
      (speed_i == spd_10 && !lp && $rose(tx_clk_o)) ##1 (speed_i == spd_10 && !lp) |=> !tx_clk_o)
      else $error("transmit clock half period wrong at 10 Mbps");

   a_crs_follow: assert property ( // RULE_18
      @(posedge clk_i) disable iff (srst_i)
      (!rgmii && !lp) |=> (crs_o == $past(carrier_i)))
      else $error("carrier sense does not follow carrier");

   a_col_fdx: assert property ( // RULE_19
      @(posedge clk_i) disable iff (srst_i)
      full_duplex_i |=> !col_o)
      else $error("collision shown in full duplex");

   a_low_power: assert property ( // RULE_20
      @(posedge clk_i) disable iff (srst_i)
      lp |=> (!rx_clk_o && !rx_dv_o && !tx_valid_o && !tx_clk_o && low_power_o && !rx_ready_o))
      else $error("port active during soft power down");

endmodule : pmp_mac_port

// File: pmp_mac_model.sv
// mac side model: drives the transmit pins and captures the receive pins
`timescale 1ns/100ps
module pmp_mac_model (
   input wire logic clk_i,
   input wire logic rgmii_mode_i,
   input wire logic rx_clk_i,
   input wire logic [7:0] rxd_i,
   input wire logic rx_dv_i,
   input wire logic rx_er_i,
   input wire logic tx_clk_i,
   output logic gtx_clk_o,
   output logic [7:0] txd_o,
   output logic tx_en_o,
   output logic tx_er_o,
   output logic got_o,
   output logic [8:0] got_word_o
);
   logic rx_clk_q;
   logic [3:0] lo_nib;
   logic lo_dv;
   logic [7:0] jk;

   initial begin
      gtx_clk_o = 1'b0;
      txd_o = 8'h00;
      tx_en_o = 1'b0;
      tx_er_o = 1'b0;
      jk = 8'h3c;
   end

   // receive edges found on the system clock, data already settled before them
   always_ff @(posedge clk_i) begin
      rx_clk_q <= rx_clk_i;
      got_o <= 1'b0;
      if (rx_clk_i && !rx_clk_q) begin
         lo_nib <= rxd_i[3:0];
         lo_dv <= rx_er_i;
         if (!rgmii_mode_i && rx_dv_i) begin
            got_o <= 1'b1;
            got_word_o <= {rx_er_i, rxd_i};
         end
      end
      if (!rx_clk_i && rx_clk_q && rgmii_mode_i && lo_dv) begin
         got_o <= 1'b1;
         got_word_o <= {rx_er_i ^ lo_dv, rxd_i[3:0], lo_nib};
      end
   end

   // one byte per call; gtx runs far below 125 mhz since the port samples it on a 10 mhz clock
   task automatic send(input logic [7:0] b, input logic en, input logic er);
      jk = jk + 8'h5b;
      @(negedge clk_i);
      if (rgmii_mode_i) begin
         txd_o = {jk[3:0], b[3:0]};
         tx_en_o = jk[4];
         tx_er_o = en;
      end else begin
         txd_o = en ? b : ~b;
         tx_en_o = en;
         tx_er_o = er;
      end
      repeat (4) @(negedge clk_i);
      gtx_clk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      if (rgmii_mode_i) begin
         txd_o = {jk[7:4], b[7:4]};
         tx_er_o = en ^ er;
      end
      repeat (4) @(negedge clk_i);
      gtx_clk_o = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask : send

   // gmii below gigabit: the mac follows the port's transmit clock, one byte per period
   task automatic send_slow(input logic [7:0] b, input logic en, input logic er);
      @(posedge tx_clk_i);
      @(negedge clk_i);
      txd_o = en ? b : ~b;
      tx_en_o = en;
      tx_er_o = er;
   endtask : send_slow
endmodule : pmp_mac_model

// File: pmp_mac_port_test.sv
// self-checking bench for the mac port
`timescale 1ns/100ps
module pmp_mac_port_test;
   import pmp_pkg::*;
   logic clk_i, srst_i, rgmii_mode, soft_n, rec_clk, rx_err, rx_valid, carrier, collision, full_duplex;
   pmp_speed_t speed;
   logic [7:0] rx_data, rxd, txd, tx_data;
   logic rx_ready, rx_clk, rx_dv, rx_er, crs, col, gtx, tx_en, tx_er, tx_clk, tx_err, tx_valid, tx_sof;
   logic low_power, got, slow_tx;
   logic [8:0] got_word;
   logic [8:0] rx_q[$];
   logic [9:0] tx_q[$];
   logic [31:0] seed;
   int n_errors, n_checks, cyc;

   pmp_mac_port pmp_mac_port_inst (.clk_i(clk_i), .srst_i(srst_i), .rgmii_mode_i(rgmii_mode), .speed_i(speed),
      .soft_powerdown_reset_n_i(soft_n), .rec_clk_i(rec_clk), .rx_data_i(rx_data), .rx_err_i(rx_err),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .carrier_i(carrier), .collision_i(collision),
      .full_duplex_i(full_duplex), .rx_clk_o(rx_clk), .rxd_o(rxd), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
      .crs_o(crs), .col_o(col), .gtx_clk_i(gtx), .txd_i(txd), .tx_en_i(tx_en), .tx_er_i(tx_er),
      .tx_clk_o(tx_clk), .tx_data_o(tx_data), .tx_err_o(tx_err), .tx_valid_o(tx_valid), .tx_sof_o(tx_sof),
      .low_power_o(low_power));

   pmp_mac_model pmp_mac_model_inst (.clk_i(clk_i), .rgmii_mode_i(rgmii_mode), .rx_clk_i(rx_clk),
      .rxd_i(rxd), .rx_dv_i(rx_dv), .rx_er_i(rx_er), .tx_clk_i(tx_clk), .gtx_clk_o(gtx), .txd_o(txd), .tx_en_o(tx_en),
      .tx_er_o(tx_er), .got_o(got), .got_word_o(got_word));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // back to back words overrun the two-entry buffer, so refusals are exercised
   task automatic push_burst(input int n);
      int i, k;
      for (i = 0; i < n; i++) begin
         seed = lfsr(seed);
         @(negedge clk_i);
         rx_valid = 1'b1;
         rx_data = seed[7:0];
         rx_err = seed[8] & seed[9];
         k = 0;
         @(posedge clk_i);
         while (rx_ready !== 1'b1 && k < 100) begin
            k++;
            @(posedge clk_i);
         end
         rx_q.push_back({rx_err, rx_data});
      end
      @(negedge clk_i);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask : push_burst

   // n enabled bytes then one idle byte to close the frame
   task automatic frame(input int n);
      int i;
      logic [9:0] w;
      for (i = 0; i <= n; i++) begin
         seed = lfsr(seed);
         w = {i == 0, seed[9] & seed[10], seed[7:0]};
         if (i < n) begin
            tx_q.push_back(w);
         end
         if (slow_tx) begin
            pmp_mac_model_inst.send_slow(w[7:0], i < n, w[8]);
         end else begin
            pmp_mac_model_inst.send(w[7:0], i < n, w[8]);
         end
      end
   endtask : frame

   task automatic drain();
      int k;
      k = 0;
      while (rx_q.size() + tx_q.size() != 0 && k < 3000) begin
         k++;
         @(negedge clk_i);
      end
      check("words left over", rx_q.size() + tx_q.size(), 0);
   endtask : drain

   task automatic count_txclk(input pmp_speed_t s, input int exp);
      int n;
      logic p;
      @(negedge clk_i);
      speed = s;
      repeat (10) @(negedge clk_i);
      n = 0;
      p = tx_clk;
      repeat (40) begin
         @(negedge clk_i);
         if (tx_clk === 1'b1 && p === 1'b0) begin
            n++;
         end
         p = tx_clk;
      end
      check("tx clock rises", n, exp);
   endtask : count_txclk

   task automatic side_pins(input logic car, input logic cl, input logic fd, input logic [1:0] exp);
      @(negedge clk_i);
      carrier = car;
      collision = cl;
      full_duplex = fd;
      repeat (3) @(negedge clk_i);
      check("carrier and collision", {crs, col}, exp);
   endtask : side_pins

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // recovered clock free runs, phase unrelated to the system clock
   initial begin
      rec_clk = 1'b0;
      #137;
      forever #400 rec_clk = ~rec_clk;
   end

   // scoreboard: oldest note is compared whenever a result appears
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 30000) begin
         n_errors++;
         report_and_stop();
      end
      if (got === 1'b1) begin
         check("rx word", got_word, rx_q.size() ? rx_q.pop_front() : 9'h1ff);
         if (rgmii_mode) begin
            check("rgmii unused outputs", {rxd[7:4], rx_dv, crs, col}, 0);
         end
      end
      if (tx_valid === 1'b1) begin
         check("tx word", {tx_sof, tx_err, tx_data}, tx_q.size() ? tx_q.pop_front() : 10'h3ff);
      end
   end

   initial begin
      seed = 32'h2b3e_afcb;
      n_errors = 0;
      n_checks = 0;
      cyc = 0;
      slow_tx = 1'b0;
      srst_i = 1'b1;
      rgmii_mode = 1'b0;
      speed = spd_1000;
      soft_n = 1'b1;
      rx_data = 8'h00;
      rx_err = 1'b0;
      rx_valid = 1'b0;
      carrier = 1'b0;
      collision = 1'b0;
      full_duplex = 1'b0;
      repeat (4) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      count_txclk(spd_10, 10);
      count_txclk(spd_100, 20);
      count_txclk(spd_1000, 0);
      fork
         push_burst(12);
         frame(5);
      join
      frame(1);
      // gmii at 10 Mbps captures on the port's own transmit clock
      speed = spd_10;
      slow_tx = 1'b1;
      frame(3);
      slow_tx = 1'b0;
      drain();
      side_pins(1'b1, 1'b1, 1'b0, 2'b11);
      side_pins(1'b1, 1'b1, 1'b1, 2'b10);
      side_pins(1'b0, 1'b0, 1'b0, 2'b00);
      soft_n = 1'b0;
      repeat (6) @(negedge clk_i);
      check("power down", {low_power, rx_ready}, 2'b10);
      soft_n = 1'b1;
      repeat (6) @(negedge clk_i);
      check("power up", {low_power, rx_ready}, 2'b01);
      rgmii_mode = 1'b1;
      repeat (8) @(negedge clk_i);
      fork
         push_burst(12);
         frame(4);
      join
      speed = spd_10;
      frame(3);
      drain();
      side_pins(1'b1, 1'b1, 1'b0, 2'b00);
      report_and_stop();
   end
endmodule : pmp_mac_port_test
